// ---- rtl/hsc_cfg.svh ----
// constants of the hot swap control and alert register bank
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH
// ==================== command byte offsets
`define HSC_OFS_CTRL_LO   8'h00
`define HSC_OFS_CTRL_HI   8'h01
`define HSC_OFS_ALERT_LO  8'h02
`define HSC_OFS_ALERT_HI  8'h03
`define HSC_OFS_FAULT_LOG 8'h04
`define HSC_OFS_ALARM_LOG 8'h05
`define HSC_OFS_FB_TIME   8'h06
`define HSC_OFS_ALERT_CTL 8'h1C
// ==================== reset values
`define HSC_RST_CTRL_LO   8'hBB
`define HSC_RST_CTRL_HI   8'h02
`define HSC_RST_ALERT     8'h00
`define HSC_RST_LOG       8'h00
`define HSC_RST_FB_TIME   8'hFF
// ==================== low control byte bit positions
`define HSC_B_FAULT_MASK  7
`define HSC_B_ON_DELAY    6
`define HSC_B_POLARITY    5
`define HSC_B_BCAST_ALLOW 4
`define HSC_B_SWITCH_ON   3
`define HSC_B_OC_RETRY    2
`define HSC_B_UV_RETRY    1
`define HSC_B_OV_RETRY    0
// ==================== fault log bit positions
`define HSC_F_SW_BAD      6
`define HSC_F_PIN_CHANGE  4
`define HSC_F_OC          2
`define HSC_F_UV          1
`define HSC_F_OV          0
// ==================== alert control bit positions
`define HSC_A_CLEAR       6
`define HSC_A_FORCE_LOW   5
// ==================== timing
`define HSC_CLK_HZ        50000000
`define HSC_DEBOUNCE_MS   50
`define HSC_RETRY_MS      50
`define HSC_OC_TICKS      256
`define HSC_MS_CYC        (`HSC_CLK_HZ / 1000)
`endif

// ---- rtl/hsc_pkg.sv ----
// types shared by the hot swap control and alert register bank
package hsc_pkg;
    // ==================== switch sequencing
    typedef enum logic [1:0] {
        SW_OFF,
        SW_DEBOUNCE,
        SW_ON,
        SW_RETRY
    } hsc_sw_e;

    // ==================== byte register port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bcast;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hsc_req_s;

    // ==================== threshold selections
    typedef struct packed {
        logic [1:0] power_good_threshold_sel;
        logic [1:0] low_input_threshold_sel;
        logic [1:0] high_input_threshold_sel;
        logic [1:0] input_range_sel;
    } hsc_sel_s;

    // ==================== whole block state
    typedef struct packed {
        logic [7:0]  ctrl_lo;
        hsc_sel_s    ctrl_hi;
        logic [7:0]  alert_lo;
        logic [7:0]  alert_hi;
        logic [7:0]  fault_log;
        logic [7:0]  alarm_log;
        logic [7:0]  fb_time;
        logic        force_low;
        logic        pin_q;
        logic        pin_valid;
        hsc_sw_e     sw;
        logic [21:0] cnt;
        logic [15:0] ms_cnt;
        logic [7:0]  fb_ms;
        logic [7:0]  rdata;
        logic        alert_n;
        logic        switch_on;
    } hsc_state_s;
endpackage : hsc_pkg

// ---- rtl/hsc_regs.sv ----
// hot swap on/off control, alert enables, fault and alarm logs
`timescale 1ns/1ps
`include "hsc_cfg.svh"

// Behaviour
// - fault mask stops pin clearing fault log
// - delay bit adds 50ms switch-on debounce
// - polarity bit sets enable pin active level
// - broadcast writes accepted only when allowed
// - software switch-on bit overrides enable pin
// - overcurrent retry after 256 timer cycles
// - undervoltage retry after 50ms when enabled
// - overvoltage retry after 50ms when enabled
// - power-good threshold select field
// - undervoltage threshold select field
// - overvoltage threshold select field
// - input range select field, default 12V
// - low alert byte enables fault alerts
// - high alert byte enables alarm alerts
// - fault log bits set by events
// - pin change sets fault log bit 4
// - high alarm bits set above maximum
// - low alarm bits set below minimum
// - switch-bad wait in milliseconds, default 255
// - zero wait disables switch-bad detection
// - alert control clears alerts, forces low
module hsc_regs #(
    parameter int DEBOUNCE_CYC   = `HSC_DEBOUNCE_MS * `HSC_MS_CYC,
    parameter int RETRY_CYC      = `HSC_RETRY_MS * `HSC_MS_CYC,
    parameter int TIMER_TICK_CYC = 1,
    parameter int MS_CYC         = `HSC_MS_CYC
) (
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    // byte register port, one request per strobe
    input  wire hsc_pkg::hsc_req_s req_i,
    output logic [7:0]            rdata_o,
    // enable pin and device events
    input  wire logic             enable_pin_i,
    input  wire logic [7:0]       fault_evt_i,
    input  wire logic [7:0]       alarm_evt_i,
    input  wire logic             switch_degraded_i,
    // switch, selections and alert
    output logic                  switch_on_o,
    output hsc_pkg::hsc_sel_s     sel_o,
    output logic                  alert_n_o
);
    import hsc_pkg::*;

    localparam int OC_RETRY_CYC = `HSC_OC_TICKS * TIMER_TICK_CYC;

    hsc_state_s q;
    hsc_state_s next_q;

    // ==================== combinational next state
    // every register and counter lives in one struct so reset and update stay uniform
    always_comb begin
        logic       wr_ok;
        logic       pin_act;
        logic       pin_prev;
        logic       pin_rise;
        logic       pin_fall;
        logic [7:0] f_evt;
        logic       clr_logs;
        logic       fb_fault;
        next_q    = q;
        wr_ok     = req_i.wr && (!req_i.bcast || q.ctrl_lo[`HSC_B_BCAST_ALLOW]);
        pin_act   = enable_pin_i ~^ q.ctrl_lo[`HSC_B_POLARITY];
        pin_prev  = q.pin_q;
        pin_rise  = q.pin_valid && pin_act && !pin_prev;
        pin_fall  = q.pin_valid && !pin_act && pin_prev;
        f_evt     = fault_evt_i;
        f_evt[`HSC_F_PIN_CHANGE] = pin_rise || pin_fall;
        clr_logs  = 1'b0;
        fb_fault  = 1'b0;
        next_q.pin_q     = pin_act;
        next_q.pin_valid = 1'b1;

        // switch-bad wait counts whole milliseconds while degraded and on
        if (q.sw == SW_ON && switch_degraded_i && q.fb_time != `HSC_RST_LOG) begin
            if (q.ms_cnt == 16'(MS_CYC - 1)) begin
                next_q.ms_cnt = '0;
                next_q.fb_ms  = q.fb_ms + 8'h01;
                if (q.fb_ms + 8'h01 >= q.fb_time) begin
                    fb_fault = 1'b1;
                end
            end else begin
                next_q.ms_cnt = q.ms_cnt + 16'h0001;
            end
        end else begin
            next_q.ms_cnt = '0;
            next_q.fb_ms  = '0;
        end
        f_evt[`HSC_F_SW_BAD] = fault_evt_i[`HSC_F_SW_BAD] || fb_fault;

        // switch sequencing: pin first, faults next, software write last
        unique case (q.sw)
            SW_OFF: begin
                if (pin_rise) begin
                    if (q.ctrl_lo[`HSC_B_ON_DELAY]) begin
                        next_q.sw  = SW_DEBOUNCE;
                        next_q.cnt = '0;
                    end else begin
                        next_q.sw = SW_ON;
                    end
                end
            end
            SW_DEBOUNCE: begin
                next_q.cnt = q.cnt + 22'h000001;
                if (!pin_act) begin
                    next_q.sw = SW_OFF;
                end else if (q.cnt == 22'(DEBOUNCE_CYC - 1)) begin
                    next_q.sw = SW_ON;
                end
            end
            SW_ON: begin
                if (pin_fall) begin
                    next_q.sw = SW_OFF;
                end
            end
            SW_RETRY: begin
                if (q.cnt == '0) begin
                    next_q.sw = SW_ON;
                end else begin
                    next_q.cnt = q.cnt - 22'h000001;
                end
            end
        endcase

        // a fault while on switches off, with a retry where enabled
        if (q.sw == SW_ON) begin
            if (f_evt[`HSC_F_OC]) begin
                next_q.sw  = q.ctrl_lo[`HSC_B_OC_RETRY] ? SW_RETRY : SW_OFF;
                next_q.cnt = 22'(OC_RETRY_CYC - 1);
            end else if (f_evt[`HSC_F_UV]) begin
                next_q.sw  = q.ctrl_lo[`HSC_B_UV_RETRY] ? SW_RETRY : SW_OFF;
                next_q.cnt = 22'(RETRY_CYC - 1);
            end else if (f_evt[`HSC_F_OV]) begin
                next_q.sw  = q.ctrl_lo[`HSC_B_OV_RETRY] ? SW_RETRY : SW_OFF;
                next_q.cnt = 22'(RETRY_CYC - 1);
            end else if (f_evt[`HSC_F_SW_BAD]) begin
                next_q.sw = SW_OFF;
            end
        end

        // pin going active clears the fault log unless masked
        if (pin_rise && !q.ctrl_lo[`HSC_B_FAULT_MASK]) begin
            next_q.fault_log = '0;
        end

        // register writes; logs store the written byte
        if (wr_ok) begin
            unique case (req_i.addr)
                `HSC_OFS_CTRL_LO: begin
                    next_q.ctrl_lo = req_i.wdata;
                    next_q.sw = req_i.wdata[`HSC_B_SWITCH_ON] ? SW_ON : SW_OFF;
                end
                `HSC_OFS_CTRL_HI:   next_q.ctrl_hi   = req_i.wdata;
                `HSC_OFS_ALERT_LO:  next_q.alert_lo  = req_i.wdata;
                `HSC_OFS_ALERT_HI:  next_q.alert_hi  = req_i.wdata;
                `HSC_OFS_FAULT_LOG: next_q.fault_log = req_i.wdata;
                `HSC_OFS_ALARM_LOG: next_q.alarm_log = req_i.wdata;
                `HSC_OFS_FB_TIME:   next_q.fb_time   = req_i.wdata;
                `HSC_OFS_ALERT_CTL: begin
                    next_q.force_low = req_i.wdata[`HSC_A_FORCE_LOW];
                    clr_logs = req_i.wdata[`HSC_A_CLEAR];
                end
                default: ;
            endcase
        end
        if (clr_logs) begin
            next_q.fault_log = '0;
            next_q.alarm_log = '0;
        end

        // new events set log bits after any clear, so a set wins
        next_q.fault_log = next_q.fault_log | f_evt;
        next_q.alarm_log = next_q.alarm_log | alarm_evt_i;

        // switch_on_command bit reads back the switch state
        next_q.ctrl_lo[`HSC_B_SWITCH_ON] = (next_q.sw == SW_ON);
        next_q.switch_on = (next_q.sw == SW_ON);

        // alert is low while any enabled log bit stands or software forces it
        next_q.alert_n = !(|(next_q.fault_log & next_q.alert_lo) ||
                           |(next_q.alarm_log & next_q.alert_hi) ||
                           next_q.force_low);

        // read data, one cycle after the strobe; unmapped reads zero
        if (req_i.rd) begin
            unique case (req_i.addr)
                `HSC_OFS_CTRL_LO:   next_q.rdata = q.ctrl_lo;
                `HSC_OFS_CTRL_HI:   next_q.rdata = q.ctrl_hi;
                `HSC_OFS_ALERT_LO:  next_q.rdata = q.alert_lo;
                `HSC_OFS_ALERT_HI:  next_q.rdata = q.alert_hi;
                `HSC_OFS_FAULT_LOG: next_q.rdata = q.fault_log;
                `HSC_OFS_ALARM_LOG: next_q.rdata = q.alarm_log;
                `HSC_OFS_FB_TIME:   next_q.rdata = q.fb_time;
                `HSC_OFS_ALERT_CTL: begin
                    next_q.rdata = '0;
                    next_q.rdata[`HSC_A_FORCE_LOW] = q.force_low;
                end
                default:            next_q.rdata = '0;
            endcase
        end
    end

    // ==================== state register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q           <= '0;
            q.ctrl_lo   <= `HSC_RST_CTRL_LO;
            q.ctrl_hi   <= `HSC_RST_CTRL_HI;
            q.alert_lo  <= `HSC_RST_ALERT;
            q.alert_hi  <= `HSC_RST_ALERT;
            q.fault_log <= `HSC_RST_LOG;
            q.alarm_log <= `HSC_RST_LOG;
            q.fb_time   <= `HSC_RST_FB_TIME;
            q.sw        <= SW_ON;   // switch_on_command defaults to 1
            q.switch_on <= 1'b1;
            q.alert_n   <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // ==================== outputs, all from state flops
    assign rdata_o     = q.rdata;
    assign switch_on_o = q.switch_on;
    assign sel_o       = q.ctrl_hi;
    assign alert_n_o   = q.alert_n;
endmodule : hsc_regs

// ---- testbench/hsc_host.sv ----
// host model driving byte reads and writes on the register port
`timescale 1ns/1ps
module hsc_host (
    // clock and request
    input  wire logic         mclk_i,
    output hsc_pkg::hsc_req_s req_o
);
    import hsc_pkg::*;
    // ==================== idle until a transfer
    initial req_o = '0;
    // hold over one taking edge, then idle a cycle so no byte is taken twice
    task automatic xfer(input logic w, r, b, input logic [7:0] a, d);
        req_o = '{wr: w, rd: r, bcast: b, addr: a, wdata: d};
        @(posedge mclk_i);
        #1 req_o = '0;
        @(posedge mclk_i);
        #1;
    endtask : xfer
endmodule : hsc_host

// ---- testbench/hsc_regs_assertions.sv ----
// port assertions of the hot swap control and alert register bank
`timescale 1ns/1ps
module hsc_regs_chk (
    // clock and reset
    input wire logic              mclk_i,
    input wire logic              rst_i,
    // register port
    input wire hsc_pkg::hsc_req_s req_i,
    input wire logic [7:0]        rdata_o,
    // pins and events
    input wire logic              enable_pin_i,
    input wire logic [7:0]        fault_evt_i,
    input wire logic [7:0]        alarm_evt_i,
    input wire logic              switch_degraded_i,
    // outputs
    input wire logic              switch_on_o,
    input wire hsc_pkg::hsc_sel_s sel_o,
    input wire logic              alert_n_o
);
    import hsc_pkg::*;
    // ==================== control byte shadow
    logic [7:0] ctl;
    wire        wok = req_i.wr && (!req_i.bcast || ctl[4]);
    wire        cw  = wok && req_i.addr == 8'h00;
    wire        sw  = wok && req_i.addr == 8'h01;
    wire        act = |{fault_evt_i, alarm_evt_i, req_i.wr, switch_degraded_i};
    // broadcast, polarity and delay checks all hinge on the last accepted control byte
    always_ff @(posedge mclk_i) begin
        if (rst_i) ctl <= 8'hBB;
        else if (cw) ctl <= req_i.wdata;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // ==================== assertions
    a_reset_dflt: assert property ($fell(rst_i) |-> sel_o == 8'h02 && switch_on_o && alert_n_o)
        else $error("outputs not at defaults after reset");
    a_sel_write: assert property (sw |=> sel_o == $past(req_i.wdata))
        else $error("selection byte not taken");
    a_sel_hold: assert property (!$past(sw) |-> $stable(sel_o))
        else $error("selection changed without accepted write");
    a_switch_cmd: assert property (cw |=> switch_on_o == $past(req_i.wdata[3]))
        else $error("switch does not follow command bit");
    a_fault_off: assert property (|fault_evt_i[2:0] && switch_on_o && !req_i.wr
        |-> ##[1:2] !switch_on_o)
        else $error("switch stays on after fault");
    a_pin_off: assert property (ctl[5] && $fell(enable_pin_i) && !req_i.wr
        |-> ##[1:3] !switch_on_o)
        else $error("switch stays on with pin inactive");
    a_delay_on: assert property (ctl[6] && ctl[5] && $rose(enable_pin_i) && !switch_on_o
        |=> !switch_on_o [*8])
        else $error("switch on before debounce");
    a_alert_fall: assert property ($fell(alert_n_o)
        |-> $past(act) || $past(enable_pin_i) != $past(enable_pin_i, 4))
        else $error("alert without cause");
    a_alert_rise: assert property ($rose(alert_n_o)
        |-> $past(req_i.wr) || $past(enable_pin_i) != $past(enable_pin_i, 4))
        else $error("alert released without clear");
    // ==================== covers
    c_alert: cover property ($fell(alert_n_o));
    c_bcast_drop: cover property (req_i.wr && req_i.bcast && !ctl[4]);
    c_retry: cover property ($rose(switch_on_o) && !$past(req_i.wr));
endmodule : hsc_regs_chk

bind hsc_regs hsc_regs_chk u_chk (.mclk_i, .rst_i, .req_i, .rdata_o, .enable_pin_i,
    .fault_evt_i, .alarm_evt_i, .switch_degraded_i, .switch_on_o, .sel_o, .alert_n_o);

// ---- testbench/test_hot_swap_control_alert_regs.sv ----
// self-checking bench of the hot swap control and alert register bank
`timescale 1ns/1ps
module test_hot_swap_control_alert_regs;
    import hsc_pkg::*;
    // ==================== signals
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        pin = 1'b1;
    logic        bad = 1'b0;
    logic [7:0]  fev = 8'h00;
    logic [7:0]  aev = 8'h00;
    logic        rd_q = 1'b0;
    logic [7:0]  rdat;
    logic        sw_on;
    logic        alert_n;
    hsc_req_s    req;
    hsc_sel_s    sel;
    logic [7:0]  exp_q[$];
    logic [7:0]  rv[7] = '{8'hBB, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
    logic [31:0] seed = 32'h00010523;
    int          err_count = 0;
    int          n_tests = 0;
    // 50 MHz clock
    always #10 mclk = !mclk;
    hsc_host u_host (.mclk_i(mclk), .req_o(req));
    // short counts keep debounce, undervoltage/overvoltage retry and millisecond waits to a few dozen cycles
    hsc_regs #(.DEBOUNCE_CYC(20), .RETRY_CYC(20), .TIMER_TICK_CYC(1), .MS_CYC(10)) u_dut (
        .mclk_i(mclk), .rst_i(rst), .req_i(req), .rdata_o(rdat), .enable_pin_i(pin),
        .fault_evt_i(fev), .alarm_evt_i(aev), .switch_degraded_i(bad),
        .switch_on_o(sw_on), .sel_o(sel), .alert_n_o(alert_n));
    // ==================== helpers
    task automatic complete_run();
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chb(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : chb
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, d, input logic b = 1'b0);
        u_host.xfer(1'b1, 1'b0, b, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, 1'b1, 1'b0, a, 8'h00);
    endtask : rd
    // events are one-cycle pulses
    task automatic pulse(input logic [7:0] f, a);
        fev = f;
        aev = a;
        cyc(1);
        fev = 8'h00;
        aev = 8'h00;
        cyc(2);
    endtask : pulse
    // bounded wait: running out is a mismatch and ends the run
    task automatic wait_sw(input logic e, input int n);
        for (int i = 0; i < n && sw_on !== e; i++) cyc(1);
        chb(sw_on, e);
        if (sw_on !== e) complete_run();
    endtask : wait_sw
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs
    // ==================== read answers against the oldest note
    always @(posedge mclk) begin
        if (rd_q) chk(rdat, exp_q.pop_front());
        rd_q <= req.rd;
    end
    // ==================== main sequence
    initial begin
        logic [7:0] v;
        cyc(10);
        rst = 1'b0;
        foreach (rv[i]) rd(i[7:0], rv[i]);
        rd(8'h50, 8'h00);
        chk({6'h00, sw_on, alert_n}, 8'h03);
        for (int i = 0; i < 5; i++) begin
            v = (i < 4) ? {4{i[1:0]}} : xs();
            wr(8'h01, v);
            chk(sel, v);
            rd(8'h01, v);
        end
        wr(8'h02, 8'h04);
        pulse(8'h02, 8'h00);
        chb(alert_n, 1'b1);
        chb(sw_on, 1'b0);
        wait_sw(1'b1, 40);
        pulse(8'h04, 8'h00);
        chb(alert_n, 1'b0);
        rd(8'h04, 8'h06);
        rd(8'h00, 8'hB3);
        cyc(300);
        chb(sw_on, 1'b0);
        wr(8'h04, 8'h00);
        chb(alert_n, 1'b1);
        wr(8'h00, 8'hBF);
        chb(sw_on, 1'b1);
        pulse(8'h04, 8'h00);
        cyc(240);
        chb(sw_on, 1'b0);
        wait_sw(1'b1, 40);
        wr(8'h04, 8'h00);
        wr(8'h00, 8'hBB);
        pin = 1'b0;
        cyc(4);
        chb(sw_on, 1'b0);
        wr(8'h04, 8'h01);
        pin = 1'b1;
        cyc(3);
        chb(sw_on, 1'b1);
        rd(8'h04, 8'h11);
        wr(8'h00, 8'h73);
        pin = 1'b0;
        cyc(4);
        wr(8'h04, 8'h01);
        pin = 1'b1;
        cyc(10);
        chb(sw_on, 1'b0);
        wait_sw(1'b1, 20);
        rd(8'h04, 8'h10);
        wr(8'h00, 8'hAB);
        wr(8'h06, 8'h11, 1'b1);
        rd(8'h06, 8'hFF);
        wr(8'h00, 8'hBB);
        wr(8'h06, 8'h02, 1'b1);
        rd(8'h06, 8'h02);
        bad = 1'b1;
        cyc(10);
        chb(sw_on, 1'b1);
        wait_sw(1'b0, 30);
        bad = 1'b0;
        rd(8'h04, 8'h50);
        wr(8'h00, 8'hBB);
        wr(8'h06, 8'h00);
        bad = 1'b1;
        cyc(100);
        chb(sw_on, 1'b1);
        bad = 1'b0;
        wr(8'h03, 8'h01);
        pulse(8'h00, 8'h81);
        rd(8'h05, 8'h81);
        chb(alert_n, 1'b0);
        wr(8'h1C, 8'h40);
        rd(8'h05, 8'h00);
        chb(alert_n, 1'b1);
        wr(8'h1C, 8'h20);
        chb(alert_n, 1'b0);
        cyc(2);
        complete_run();
    end
endmodule : test_hot_swap_control_alert_regs
